// [design/recorder_pkg.sv]
package recorder_pkg;
   // serial frame layout
   localparam int CTRL_BITS  = 8;
   localparam int ADDR_BITS  = 16;
   localparam int FRAME_BITS = 24;
   // control byte fields (msb first): run, play/rec, message-skip select
   localparam int CTRL_RUN_BIT  = 7;
   localparam int CTRL_PLAY_BIT = 6;
   localparam int CTRL_IAB_BIT  = 4;
   localparam int CTRL_SKIP_BIT = 3;
   // status shifted out on miso: full flag first, then end flag
   localparam int STAT_FULL_BIT = 1;
   localparam int STAT_END_BIT  = 0;
   // clocks
   localparam longint CLOCK_HZ        = 64'd25000000;
   localparam longint SAMPLE_CLOCK_HZ = 64'd512000;
   localparam int     SAMPLE_DIVIDE   = 2;
   localparam longint SAMPLE_RATE_HZ  = 64'd4000;
   // row timing, in ns
   localparam longint ROW_HIGH_NS      = 64'd350000000;
   localparam longint ROW_LOW_NS       = 64'd50000000;
   localparam longint SKIP_HIGH_NS     = 64'd218760;
   localparam longint SKIP_LOW_NS      = 64'd31260;
   localparam int     ROW_COUNT        = 2400;
   localparam int     ROW_MARK_SLOTS   = 8;
   // row phases in samples at the sample rate (350 ms and 50 ms at 4 kHz)
   localparam int ROW_HIGH_SAMPLES = int'(ROW_HIGH_NS * SAMPLE_RATE_HZ / 64'd1000000000);
   localparam int ROW_LOW_SAMPLES  = int'(ROW_LOW_NS * SAMPLE_RATE_HZ / 64'd1000000000);
   // skip phases in system clock cycles, rounded down
   localparam int SKIP_HIGH_CYCLES = int'(SKIP_HIGH_NS * CLOCK_HZ / 64'd1000000000);
   localparam int SKIP_LOW_CYCLES  = int'(SKIP_LOW_NS * CLOCK_HZ / 64'd1000000000);
   // internal oscillator: system cycles per sample (25 MHz / 4 kHz)
   localparam int OSC_CYCLES_PER_SAMPLE = int'(CLOCK_HZ / SAMPLE_RATE_HZ);
   // external clock edges per sample after the halving
   localparam int EXT_EDGES_PER_SAMPLE =
      int'(SAMPLE_CLOCK_HZ / (SAMPLE_RATE_HZ * SAMPLE_DIVIDE));
   localparam logic [15:0] LAST_ADDR = 16'(ROW_COUNT * ROW_MARK_SLOTS - 1);
endpackage

// [design/serial_if.sv]
`timescale 1ns/1ns
`default_nettype none
// carries a decoded frame from the serial front end to the control core
interface serial_if;
   logic        frame_start;  // select fell
   logic        frame_done;   // select rose
   logic [23:0] frame;        // bits shifted in at lsb, first bit reaches msb only in a 24 bit frame
   logic [5:0]  bit_count;    // bits taken in this frame
   logic [1:0]  status;       // status bits to shift out
   modport front (output frame_start, output frame_done, output frame,
                  output bit_count, input status);
   modport core  (input frame_start, input frame_done, input frame,
                  input bit_count, output status);
endinterface
`default_nettype wire

// [design/serial_front.sv]
`timescale 1ns/1ns
`default_nettype none
module serial_front
(
   input  wire logic clock,       // system clock
   input  wire logic reset_n,     // async reset
   input  wire logic enable,      // clock enable
   input  wire logic sclk_in,     // raw serial clock pin
   input  wire logic mosi_in,     // raw data pin
   input  wire logic ss_n_in,     // raw select pin
   output logic      miso_out,    // data out
   output logic      miso_oe,     // drive enable
   serial_if.front   link         // toward the core
);
   logic [1:0]  sclk_s_q, mosi_s_q, ss_s_q;
   logic        sclk_p_q, ss_p_q;
   logic [23:0] frame_q, frame_d;
   logic [5:0]  count_q, count_d;
   logic [1:0]  shout_q, shout_d;
   logic        miso_q, miso_d;
   logic        oe_q, oe_d;
   logic        start_q, start_d, done_q, done_d;
   logic        rise, fall, sel;

   ///////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sclk_s_q <= 2'h0;
         mosi_s_q <= 2'h0;
         ss_s_q   <= 2'h3;
         sclk_p_q <= 1'h0;
         ss_p_q   <= 1'h1;
      end
      else if (enable)
      begin
         sclk_s_q <= {sclk_s_q[0], sclk_in};
         mosi_s_q <= {mosi_s_q[0], mosi_in};
         ss_s_q   <= {ss_s_q[0], ss_n_in};
         sclk_p_q <= sclk_s_q[1];
         ss_p_q   <= ss_s_q[1];
      end
   end

   assign rise = sclk_s_q[1] & ~sclk_p_q;
   assign fall = ~sclk_s_q[1] & sclk_p_q;
   assign sel  = ~ss_s_q[1];

   always_comb
   begin
      frame_d = frame_q;
      count_d = count_q;
      shout_d = shout_q;
      miso_d  = miso_q;
      oe_d    = sel;
      start_d = ss_p_q & ~ss_s_q[1];
      done_d  = ~ss_p_q & ss_s_q[1];
      if (start_d)
      begin
         count_d = 6'h00;
         shout_d = {link.status[0], 1'h0};
         miso_d  = link.status[1];
      end
      else if (sel)
      begin
         if (rise && count_q < 6'(recorder_pkg::FRAME_BITS))
         begin
            frame_d = {frame_q[22:0], mosi_s_q[1]};
            count_d = count_q + 6'h01;
         end
         if (fall)
         begin
            miso_d  = shout_q[1];
            shout_d = {shout_q[0], 1'h0};
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         frame_q <= 24'h000000;
         count_q <= 6'h00;
         shout_q <= 2'h0;
         miso_q  <= 1'h0;
         oe_q    <= 1'h0;
         start_q <= 1'h0;
         done_q  <= 1'h0;
      end
      else if (enable)
      begin
         frame_q <= frame_d;
         count_q <= count_d;
         shout_q <= shout_d;
         miso_q  <= miso_d;
         oe_q    <= oe_d;
         start_q <= start_d;
         done_q  <= done_d;
      end
   end

   assign miso_out         = miso_q;
   assign miso_oe          = oe_q;
   assign link.frame       = frame_q;
   assign link.bit_count   = count_q;
   assign link.frame_start = start_q;
   assign link.frame_done  = done_q;

   property p_miso_off;
      @(posedge clock) disable iff (!reset_n)
      (enable && !sel) |=> !miso_oe;
   endproperty
   a_miso_off: assert property (p_miso_off) else $error("miso driven while deselected");

   property p_shift_count;
      @(posedge clock) disable iff (!reset_n)
      (enable && sel && !start_d && rise && count_q < 6'h18) |=> count_q == $past(count_q) + 6'h01;
   endproperty
   a_shift_count: assert property (p_shift_count) else $error("rising edge not taken");

   property p_no_shift_deselected;
      @(posedge clock) disable iff (!reset_n)
      (enable && !sel && !start_d) |=> $stable(frame_q);
   endproperty
   a_no_shift_deselected: assert property (p_no_shift_deselected) else $error("shift while idle");
endmodule
`default_nettype wire

// [design/recorder_host_port.sv]
`timescale 1ns/1ns
`default_nettype none
module recorder_host_port
(
   input  wire logic        clock,            // 25 mhz system clock
   input  wire logic        reset_n,          // async reset
   input  wire logic        enable,           // clock enable
   input  wire logic        sclk,             // serial clock pin
   input  wire logic        mosi,             // serial data in
   input  wire logic        ss_n,             // select, active low
   output logic             miso_out,         // serial data out
   output logic             miso_oe,          // miso drive enable
   output logic             int_n_out,        // interrupt pin value (always 0)
   output logic             int_n_oe,         // interrupt pulled low
   output logic             row_strobe_out,   // row strobe value (always 0)
   output logic             row_strobe_oe,    // row strobe pulled low
   input  wire logic        external_sample_clock, // 512 khz sample clock pin
   input  wire logic        use_external_clock,    // select external timing
   input  wire logic        marker_found,     // end marker seen in current slot
   output logic [15:0]      address,          // current storage address
   output logic             running,          // operation active
   output logic             playing,          // playback active (else record)
   output logic             skipping,         // message skip active
   output logic [7:0]       control           // last control byte
);
   serial_if link ();
   logic miso_w, oe_w;

   serial_front front
   (
      .clock    (clock),
      .reset_n  (reset_n),
      .enable   (enable),
      .sclk_in  (sclk),
      .mosi_in  (mosi),
      .ss_n_in  (ss_n),
      .miso_out (miso_w),
      .miso_oe  (oe_w),
      .link     (link)
   );

   ///////////////////////////////////////////////////////////////////////////
   // sample tick from internal divider or synchronised external clock
   logic [1:0]  xs_q;
   logic        xp_q, xp_d, half_q, half_d, tick_q, tick_d;
   logic [15:0] div_q, div_d;

   always_comb
   begin
      xp_d   = xs_q[1];
      half_d = half_q;
      div_d  = div_q;
      tick_d = 1'h0;
      if (use_external_clock)
      begin
         if (xs_q[1] && !xp_q)
         begin
            half_d = ~half_q;
            if (half_q)
            begin
               if (div_q >= 16'(recorder_pkg::EXT_EDGES_PER_SAMPLE - 1))
               begin
                  div_d  = 16'h0000;
                  tick_d = 1'h1;
               end
               else
                  div_d = div_q + 16'h0001;
            end
         end
      end
      else if (div_q >= 16'(recorder_pkg::OSC_CYCLES_PER_SAMPLE - 1))
      begin
         div_d  = 16'h0000;
         tick_d = 1'h1;
      end
      else
         div_d = div_q + 16'h0001;
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         xs_q   <= 2'h0;
         xp_q   <= 1'h0;
         half_q <= 1'h0;
         div_q  <= 16'h0000;
         tick_q <= 1'h0;
      end
      else if (enable)
      begin
         xs_q   <= {xs_q[0], external_sample_clock};
         xp_q   <= xp_d;
         half_q <= half_d;
         div_q  <= div_d;
         tick_q <= tick_d;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // command execution, flags and row strobe
   typedef enum {IDLE, ROW_HIGH, ROW_LOW, FIRST_HOLD} phase_t;
   phase_t      ph_q, ph_d;
   logic [23:0] cnt_q, cnt_d;
   logic [15:0] addr_q, addr_d;
   logic [7:0]  ctrl_q, ctrl_d;
   logic        run_q, run_d, play_q, play_d, skip_q, skip_d;
   logic        full_q, full_d, end_q, end_d, int_q, int_d, rs_q, rs_d;
   logic [2:0]  slot_q, slot_d;
   logic        step, row_end, hi_done, lo_done;
   logic        end_hit, full_hit;
   logic [7:0]  cb;

   assign cb   = link.frame[23 -: 8];
   assign step = skip_q ? 1'h1 : tick_q;
   assign hi_done = skip_q ? (cnt_q >= 24'(recorder_pkg::SKIP_HIGH_CYCLES - 1))
                           : (cnt_q >= 24'(recorder_pkg::ROW_HIGH_SAMPLES - 1));
   assign lo_done = skip_q ? (cnt_q >= 24'(recorder_pkg::SKIP_LOW_CYCLES - 1))
                           : (cnt_q >= 24'(recorder_pkg::ROW_LOW_SAMPLES - 1));
   assign row_end = (ph_q == ROW_LOW) && step && lo_done;
   assign end_hit  = run_q && step && play_q && marker_found;
   assign full_hit = run_q && step && !end_hit && row_end && addr_q == recorder_pkg::LAST_ADDR;
   assign link.status = {full_q, end_q};

   always_comb
   begin
      ph_d = ph_q; cnt_d = cnt_q; addr_d = addr_q; ctrl_d = ctrl_q;
      run_d = run_q; play_d = play_q; skip_d = skip_q; slot_d = slot_q;
      full_d = full_q; end_d = end_q; int_d = int_q; rs_d = 1'h0;
      if (link.frame_start)
         int_d = 1'h0;
      if (link.frame_done && link.bit_count >= 6'(recorder_pkg::CTRL_BITS))
      begin
         // control byte sits at frame top only for 24 bit frames; an 8 bit frame holds it in the low byte
         ctrl_d = (link.bit_count == 6'(recorder_pkg::CTRL_BITS)) ? link.frame[7:0] : cb;
         // an end or full event in the executing cycle still wins over the clear
         full_d = full_hit;
         end_d  = end_hit;
         if (full_hit || end_hit)
            int_d = 1'h1;
         if (ctrl_d[recorder_pkg::CTRL_RUN_BIT])
         begin
            if (!ctrl_d[recorder_pkg::CTRL_IAB_BIT] &&
                link.bit_count == 6'(recorder_pkg::FRAME_BITS))
               addr_d = link.frame[15:0];
            run_d  = 1'h1;
            play_d = ctrl_d[recorder_pkg::CTRL_PLAY_BIT];
            skip_d = ctrl_d[recorder_pkg::CTRL_PLAY_BIT] & ctrl_d[recorder_pkg::CTRL_SKIP_BIT];
            slot_d = 3'h0;
            cnt_d  = 24'h000000;
            ph_d   = ctrl_d[recorder_pkg::CTRL_PLAY_BIT] ? ROW_HIGH : FIRST_HOLD;
         end
         else
         begin
            run_d = 1'h0;
            play_d = 1'h0;
            skip_d = 1'h0;
            ph_d  = IDLE;
         end
      end
      else if (run_q && step)
      begin
         cnt_d = cnt_q + 24'h000001;
         case (ph_q)
            FIRST_HOLD:
               if (cnt_q >= 24'(recorder_pkg::ROW_LOW_SAMPLES - 1))
               begin
                  cnt_d = 24'h000000;
                  ph_d  = ROW_HIGH;
               end
            ROW_HIGH:
               if (hi_done)
               begin
                  cnt_d = 24'h000000;
                  ph_d  = ROW_LOW;
               end
            ROW_LOW:
               if (lo_done)
               begin
                  cnt_d  = 24'h000000;
                  ph_d   = ROW_HIGH;
                  addr_d = addr_q + 16'h0001;
                  slot_d = slot_q + 3'h1;
               end
            default:
               ph_d = IDLE;
         endcase
         if (play_q && marker_found)
         begin
            end_d = 1'h1;
            play_d = 1'h0;
            int_d = 1'h1;
            run_d = 1'h0;
            skip_d = 1'h0;
            ph_d  = IDLE;
            if (skip_q)
               addr_d = addr_q + 16'h0001;
         end
         else if (row_end && addr_q == recorder_pkg::LAST_ADDR)
         begin
            full_d = 1'h1;
            play_d = 1'h0;
            int_d  = 1'h1;
            run_d  = 1'h0;
            skip_d = 1'h0;
            ph_d   = IDLE;
         end
      end
      rs_d = (ph_d == ROW_LOW);
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ph_q <= IDLE; cnt_q <= 24'h000000; addr_q <= 16'h0000; ctrl_q <= 8'h00;
         run_q <= 1'h0; play_q <= 1'h0; skip_q <= 1'h0; slot_q <= 3'h0;
         full_q <= 1'h0; end_q <= 1'h0; int_q <= 1'h0; rs_q <= 1'h0;
         miso_out <= 1'h0; miso_oe <= 1'h0;
      end
      else if (enable)
      begin
         ph_q <= ph_d; cnt_q <= cnt_d; addr_q <= addr_d; ctrl_q <= ctrl_d;
         run_q <= run_d; play_q <= play_d; skip_q <= skip_d; slot_q <= slot_d;
         full_q <= full_d; end_q <= end_d; int_q <= int_d; rs_q <= rs_d;
         miso_out <= miso_w; miso_oe <= oe_w;
      end
   end

   assign int_n_out      = 1'h0;
   assign int_n_oe       = int_q;
   assign row_strobe_out = 1'h0;
   assign row_strobe_oe  = rs_q;
   assign address        = addr_q;
   assign running        = run_q;
   assign playing        = play_q;
   assign skipping       = skip_q;
   assign control        = ctrl_q;

   property p_int_clear;
      @(posedge clock) disable iff (!reset_n)
      (enable && link.frame_start && !(run_q && step)) |=> !int_n_oe;
   endproperty
   a_int_clear: assert property (p_int_clear) else $error("interrupt not released");

   property p_full_int;
      @(posedge clock) disable iff (!reset_n)
      (enable && $rose(full_q)) |-> int_n_oe && $past(running);
   endproperty
   a_full_int: assert property (p_full_int) else $error("full without interrupt");

   property p_end_play;
      @(posedge clock) disable iff (!reset_n)
      $rose(end_q) |-> $past(play_q) && int_n_oe;
   endproperty
   a_end_play: assert property (p_end_play) else $error("end flag outside playback");

   property p_status;
      @(posedge clock) disable iff (!reset_n)
      (enable && $past(enable) && link.frame_start) |-> miso_w == $past(full_q);
   endproperty
   a_status: assert property (p_status) else $error("first status bit is not the full flag");

   property p_hold_high;
      @(posedge clock) disable iff (!reset_n)
      (ph_q == FIRST_HOLD) |-> !row_strobe_oe;
   endproperty
   a_hold_high: assert property (p_hold_high) else $error("strobe low in first hold");
endmodule
`default_nettype wire

// [verif/spi_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module spi_host_model
#(
   parameter int HALF_NS = 160                 // half of the 320 ns link period
)
(
   output logic      sclk,                     // serial clock, idle low
   output logic      mosi,                     // data toward the device
   output logic      ss_n,                     // select, active low
   input  wire logic miso                      // data from the device
);
   initial
   begin
      sclk = 1'b0;
      mosi = 1'b0;
      ss_n = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // one framed transfer, msb first; miso is taken just before each falling edge,
   // at least half a link period after the device moved it
   task automatic xfer(input int nbits, input logic [23:0] tx, output logic [23:0] rx);
      rx = 24'h000000;
      ss_n = 1'b0;
      #(HALF_NS);
      for (int i = nbits - 1; i >= 0; i--)
      begin
         mosi = tx[i];
         #(HALF_NS);
         sclk = 1'b1;
         #(HALF_NS);
         rx = {rx[22:0], miso};
         sclk = 1'b0;
      end
      #(HALF_NS);
      ss_n = 1'b1;
      mosi = ~mosi;                            // released line keeps no stale value
      #(2 * HALF_NS);
   endtask

   // clock pulses with select high, only when the bench asks for them
   task automatic stray(input int n);
      repeat (n)
      begin
         mosi = ~mosi;
         #(HALF_NS);
         sclk = 1'b1;
         #(HALF_NS);
         sclk = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) check_val(nm, 32'(e), 32'(a))
module tb;
   typedef struct {
      int          nbits;
      logic [23:0] tx;
      logic [3:0]  st;                         // running, playing, skipping, addr valid
      logic [15:0] addr;
   } row_t;
   logic        clock;
   logic        reset_n;
   logic        enable;
   logic        sclk;
   logic        mosi;
   logic        ss_n;
   logic        miso_out;
   logic        miso_oe;
   wire         miso_line;
   logic        int_n_out;
   logic        int_n_oe;
   logic        row_strobe_out;
   logic        row_strobe_oe;
   logic        external_sample_clock;
   logic        use_external_clock;
   logic        marker_found;
   logic [15:0] address;
   logic        running;
   logic        playing;
   logic        skipping;
   logic [7:0]  control;
   int          errors;
   int          compares;
   int          n;
   int          lo;
   int          hi;
   logic [23:0] rx;
   row_t        rows [9];

   assign miso_line = miso_oe ? miso_out : 1'bz;

   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   initial
   begin
      external_sample_clock = 1'b0;
      // 1953 ns period, the closest whole-ns match to 512 khz
      forever
      begin
         #976 external_sample_clock = 1'b1;
         #977 external_sample_clock = 1'b0;
      end
   end

   recorder_host_port uut
   (
      .clock                 (clock),
      .reset_n               (reset_n),
      .enable                (enable),
      .sclk                  (sclk),
      .mosi                  (mosi),
      .ss_n                  (ss_n),
      .miso_out              (miso_out),
      .miso_oe               (miso_oe),
      .int_n_out             (int_n_out),
      .int_n_oe              (int_n_oe),
      .row_strobe_out        (row_strobe_out),
      .row_strobe_oe         (row_strobe_oe),
      .external_sample_clock (external_sample_clock),
      .use_external_clock    (use_external_clock),
      .marker_found          (marker_found),
      .address               (address),
      .running               (running),
      .playing               (playing),
      .skipping              (skipping),
      .control               (control)
   );

   spi_host_model host
   (
      .sclk (sclk),
      .mosi (mosi),
      .ss_n (ss_n),
      .miso (miso_line)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] a);
      compares++;
      if (a !== e)
      begin
         errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, a);
      end
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // counts cycles while the strobe drive enable holds lvl, bounded
   task automatic span(input logic lvl, output int c);
      c = 0;
      while (row_strobe_oe === lvl && c < 8000)
      begin
         @(negedge clock);
         c++;
      end
   endtask

   task automatic wait_int();
      n = 0;
      while (int_n_oe !== 1'b1 && n < 15000)
      begin
         @(negedge clock);
         n++;
      end
   endtask

   // cycles between two internal sample ticks, bounded
   task automatic tick_gap(output int c);
      c = 0;
      while (uut.tick_q !== 1'b1 && c < 15000)
      begin
         @(negedge clock);
         c++;
      end
      c = 0;
      do
      begin
         @(negedge clock);
         c++;
      end
      while (uut.tick_q !== 1'b1 && c < 15000);
   endtask

   // every drive enable must be off while reset is low
   task automatic chk_reset();
      `CHK("reset_outputs", 4'h0, {miso_oe, int_n_oe, row_strobe_oe, running});
   endtask

   // the skip low phase is a fractional cycle count, so one cycle of rounding is allowed
   function automatic int near(input int v, input int r);
      return (v >= r - 1 && v <= r + 1) ? r : v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #4000000;
      errors++;
      $display("watchdog expired");
      test_done();
   end

   initial
   begin
      errors = 0;
      compares = 0;
      reset_n = 1'b0;
      enable = 1'b1;
      use_external_clock = 1'b0;
      marker_found = 1'b0;
      rows = '{'{8, 24'h000020, 4'b0000, 16'h0000}, '{24, 24'he00010, 4'b1101, 16'h0010},
               '{8, 24'h000030, 4'b0000, 16'h0000}, '{8, 24'h0000f0, 4'b1101, 16'h0010},
               '{8, 24'h000030, 4'b0000, 16'h0000}, '{24, 24'ha00100, 4'b1001, 16'h0100},
               '{8, 24'h000030, 4'b0000, 16'h0000}, '{24, 24'hb01234, 4'b1001, 16'h0100},
               '{8, 24'h000030, 4'b0000, 16'h0000}};
      repeat (20) @(negedge clock);
      chk_reset();
      reset_n = 1'b1;
      repeat (4) @(negedge clock);
      foreach (rows[i])
      begin
         host.xfer(rows[i].nbits, rows[i].tx, rx);
         repeat (6) @(negedge clock);
         `CHK("control", rows[i].nbits == 24 ? rows[i].tx[23:16] : rows[i].tx[7:0], control);
         `CHK("mode", rows[i].st[3:1], {running, playing, skipping});
         if (rows[i].st[0])
            `CHK("address", rows[i].addr, address);
         $display("row %0d done", i);
      end
      // stray clocks and a short frame must change nothing
      fork
         host.stray(8);
         begin
            repeat (20) @(negedge clock);
            `CHK("unselected_oe", 1'b0, miso_oe);
         end
      join
      host.xfer(4, 24'h00000f, rx);
      repeat (6) @(negedge clock);
      `CHK("ignored_frames", 9'h030, {running, control});
      $display("ignore test done");
      // skip row timing, then an end marker ends the skip
      host.xfer(24, 24'he80005, rx);
      span(1'b0, n);
      span(1'b1, lo);
      span(1'b0, hi);
      `CHK("skip_low", recorder_pkg::SKIP_LOW_CYCLES, near(lo, recorder_pkg::SKIP_LOW_CYCLES));
      `CHK("skip_high", recorder_pkg::SKIP_HIGH_CYCLES, near(hi, recorder_pkg::SKIP_HIGH_CYCLES));
      // a low enable must hold the strobe low phase well past its length
      enable = 1'b0;
      repeat (1000) @(negedge clock);
      `CHK("frozen", 17'h10006, {row_strobe_oe, address});
      enable = 1'b1;
      marker_found = 1'b1;
      wait_int();
      marker_found = 1'b0;
      repeat (50) @(negedge clock);
      `CHK("end_int", 2'b10, {int_n_oe, running});
      fork
         host.xfer(8, 24'h000030, rx);
         begin
            wait (ss_n === 1'b0);
            repeat (10) @(negedge clock);
            `CHK("int_release_oe", 2'b01, {int_n_oe, miso_oe});
         end
      join
      `CHK("status_end", 2'b01, rx[7:6]);
      $display("skip test done");
      // skip from the last location runs into the end of storage
      host.xfer(24, {8'he8, recorder_pkg::LAST_ADDR}, rx);
      wait_int();
      `CHK("full_int", 1'b1, int_n_oe);
      host.xfer(8, 24'h000030, rx);
      `CHK("status_full", 2'b10, rx[7:6]);
      $display("full test done");
      // a marker during record must not raise the end flag
      tick_gap(n);
      `CHK("osc_sample_period", recorder_pkg::OSC_CYCLES_PER_SAMPLE, n);
      use_external_clock = 1'b1;
      host.xfer(24, 24'ha00000, rx);
      marker_found = 1'b1;
      repeat (3000) @(negedge clock);
      tick_gap(n);
      `CHK("ext_sample_period", recorder_pkg::OSC_CYCLES_PER_SAMPLE, near(n, recorder_pkg::OSC_CYCLES_PER_SAMPLE));
      `CHK("record_no_int", 1'b0, int_n_oe);
      host.xfer(8, 24'h000030, rx);
      `CHK("status_record", 2'b00, rx[7:6]);
      marker_found = 1'b0;
      use_external_clock = 1'b0;
      $display("record test done");
      // reset in mid operation
      host.xfer(24, 24'he00020, rx);
      repeat (6) @(negedge clock);
      reset_n = 1'b0;
      #5;
      chk_reset();
      @(negedge clock);
      reset_n = 1'b1;
      repeat (2) @(negedge clock);
      `CHK("after_reset", 18'h00000, {miso_oe, running, address});
      host.xfer(8, 24'h000020, rx);
      repeat (6) @(negedge clock);
      `CHK("control_after_reset", 8'h20, control);
      $display("reset test done");
      test_done();
   end
endmodule
`default_nettype wire
